/* File: tb.sv */
// Purpose: Self-checking bench for the handshake control block.
// Assumes: Zero wait state slave; hready is the slave's own hreadyout.
// Notes: Reads queue their expected word; a monitor checks data phases.

// ----------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hsel, hwrite, tx, msi_en, slow, rd_ph;
   logic hreadyout, hresp, rx_in, tx_pin, irq, rx_pin;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [3:0] want_n, pins_n, outs_n, act;
   logic [31:0] q[$];
   int fails, checked, seed, i, k;

   umc_modem_model model (.hclk(hclk), .slow(slow), .want_n(want_n),
      .pins_n(pins_n), .serial_rx_pin(rx_pin));

   umc_modem_ctrl dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .tx_shift_out(tx), .rx_shift_in(rx_in), .serial_rx_pin(rx_pin),
      .serial_tx_pin(tx_pin), .clear_to_send_n(pins_n[0]),
      .set_ready_n(pins_n[1]), .ring_indicator_n(pins_n[2]),
      .carrier_detect_n(pins_n[3]), .terminal_ready_n(outs_n[0]),
      .request_to_send_n(outs_n[1]), .aux_out1_n(outs_n[2]),
      .aux_out2_n(outs_n[3]), .msi_enable(msi_en),
      .modem_status_irq(irq));

   task automatic end_sim;
      if (fails == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // A slave that never answers would hang the run, so waits are capped.
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         fails++;
         end_sim();
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h000000, a};
      wait_rdy();
      htrans <= 2'h0;
      rd_ph <= ~w;
      if (w) hwdata <= d;
      else q.push_back(d);
      wait_rdy();
      rd_ph <= 1'b0;
   endtask

   task automatic ser(input logic lp);
      logic b;
      for (int j = 0; j < 8; j++) begin
         b = 1'($random(seed));
         @(posedge hclk);
         tx <= b;
         @(posedge hclk);
         #1;
         chk({rx_in, tx_pin}, {lp ? b : ~rx_pin, lp | b});
      end
   endtask

   always @(posedge hclk) begin
      if (rd_ph === 1'b1) begin
         chk(hrdata, q.pop_front());
      end
   end

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   initial begin
      seed = 81;
      {hresetn, hsel, hwrite, tx, msi_en, slow, rd_ph} = 7'h00;
      htrans = 2'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      want_n = 4'hF;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, umc_pkg::STATE_OFS, 32'h0);
      for (i = 0; i < 16; i++) begin
         bus(1'b1, umc_pkg::CTL_OFS, 32'hE0 | i);
         #1;
         chk({28'h0, outs_n}, {28'h0, ~i[3:0]});
         bus(1'b0, umc_pkg::CTL_OFS, i);
      end
      bus(1'b0, umc_pkg::SCRATCH_OFS, 32'h0);
      for (i = 0; i < 4; i++) begin
         r = $random(seed);
         bus(1'b1, umc_pkg::SCRATCH_OFS, r);
         bus(1'b0, umc_pkg::SCRATCH_OFS, r & 32'hFF);
      end
      bus(1'b1, 8'h0C, 32'hFF);
      bus(1'b0, 8'h0C, 32'h0);
      bus(1'b0, umc_pkg::CTL_OFS, 32'hF);
      bus(1'b1, umc_pkg::CTL_OFS, 32'h0);
      ser(1'b0);
      msi_en <= 1'b1;
      act = 4'h0;
      for (k = 0; k < 4; k++) begin
         @(posedge hclk);
         act[k] = 1'b1;
         want_n <= ~act;
         repeat (8) @(posedge hclk);
         #1;
         chk(irq, k != 2);
         bus(1'b0, umc_pkg::STATE_OFS, {act, k == 2 ? 4'h0 : 4'h1 << k});
         bus(1'b0, umc_pkg::STATE_OFS, {act, 4'h0});
         #1;
         chk(irq, 1'b0);
      end
      @(posedge hclk);
      slow <= 1'b1;
      msi_en <= 1'b0;
      for (k = 0; k < 4; k++) begin
         @(posedge hclk);
         act[k] = 1'b0;
         want_n <= ~act;
         repeat (8) @(posedge hclk);
         #1;
         chk(irq, 1'b0);
         bus(1'b0, umc_pkg::STATE_OFS, {act, 4'h1 << k});
      end
      @(posedge hclk);
      msi_en <= 1'b1;
      bus(1'b1, umc_pkg::CTL_OFS, 32'h10);
      want_n <= 4'($random(seed));
      repeat (6) @(posedge hclk);
      #1;
      chk({27'h0, outs_n, tx_pin}, 32'h1F);
      bus(1'b0, umc_pkg::STATE_OFS, 32'h0);
      bus(1'b1, umc_pkg::CTL_OFS, 32'h1F);
      repeat (4) @(posedge hclk);
      #1;
      chk({27'h0, outs_n, irq}, 32'h1F);
      bus(1'b0, umc_pkg::STATE_OFS, 32'hFB);
      bus(1'b1, umc_pkg::CTL_OFS, 32'h1B);
      repeat (4) @(posedge hclk);
      bus(1'b0, umc_pkg::STATE_OFS, 32'hB4);
      ser(1'b1);
      @(posedge hclk);
      want_n <= 4'hF;
      // Let the idle pin levels pass the synchroniser before leaving
      // loopback, so a stale random ring level cannot fake an edge.
      repeat (8) @(posedge hclk);
      bus(1'b1, umc_pkg::CTL_OFS, 32'h0B);
      repeat (6) @(posedge hclk);
      #1;
      chk({28'h0, outs_n}, 32'h4);
      bus(1'b0, umc_pkg::STATE_OFS, 32'h0B);
      end_sim();
   end
endmodule // tb

/* File: umc_modem_ctrl.sv */
// Purpose: Handshake control, handshake state and scratch registers of a
//    serial port, reached over AHB-Lite.
// Assumes: Transmit and receive shift logic sit outside on the same clock.
// Notes: Zero wait states; all outputs but hresp (tied low) are registered.
//
// Contract
// RQ1: Control bit 0 drives terminal ready inverted.
// RQ2: Control bit 1 drives request to send inverted.
// RQ3: Control bit 2 drives aux output one inverted.
// RQ4: Control bit 3 drives aux output two inverted.
// RQ5: Loopback marks serial output, loops transmit into receive.
// RQ6: Loopback routes handshake outputs inward, pins high.
// RQ7: Loopback change flags come from control bits.
// RQ8: Loopback keeps receive and transmit paths working.
// RQ9: Control bits 5 to 7 read zero.
// RQ10: Change flags set on change, cleared on read.
// RQ11: Status bit 0 flags clear to send change.
// RQ12: Status bit 1 flags set ready change.
// RQ13: Status bit 2 flags ring trailing edge only.
// RQ14: Status bit 3 flags carrier detect change.
// RQ15: Status bit 4 shows clear to send.
// RQ16: Status bit 5 shows set ready.
// RQ17: Status bit 6 shows ring indicator.
// RQ18: Status bit 7 shows carrier detect.
// RQ19: Scratch byte is plain read and write storage.
// RQ20: Interrupt enable bit 3 gates status interrupt.
// RQ21: Status interrupt from any flag, cleared by read.
// RQ22: Inputs synchronised; simultaneous change survives a read.
// RQ23: Loopback toggling flags only real value changes.

module umc_modem_ctrl (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic tx_shift_out,
   output logic rx_shift_in,
   input wire logic serial_rx_pin,
   output logic serial_tx_pin,
   input wire logic clear_to_send_n,
   input wire logic set_ready_n,
   input wire logic ring_indicator_n,
   input wire logic carrier_detect_n,
   output logic terminal_ready_n,
   output logic request_to_send_n,
   output logic aux_out1_n,
   output logic aux_out2_n,
   input wire logic msi_enable,
   output logic modem_status_irq
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [umc_pkg::CTL_W-1:0] ctl;
      logic [7:0] scratch;
      logic [3:0] chg;
      logic [3:0] eff;
      logic wr_pend;
      logic [umc_pkg::ADDR_W-1:0] wr_addr;
      logic [31:0] rdata;
      logic [3:0] hs_n;
      logic tx;
      logic rxin;
      logic irq;
      logic ready;
   } umc_state_s;

   localparam umc_state_s STATE_RST = '{
      ctl: umc_pkg::CTL_RST,
      scratch: umc_pkg::SCRATCH_RST,
      chg: 4'h0,
      eff: 4'h0,
      wr_pend: 1'b0,
      wr_addr: 8'h00,
      rdata: 32'h0000_0000,
      hs_n: umc_pkg::PIN_IDLE_N,
      tx: 1'b1,
      rxin: 1'b1,
      irq: 1'b0,
      ready: 1'b1
   };

   umc_state_s s_q;
   umc_state_s s_d;

   umc_sync_if sif ();

   umc_sync u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .pins_n({carrier_detect_n, ring_indicator_n, set_ready_n,
               clear_to_send_n}),
      .serial_rx_pin(serial_rx_pin),
      .sif(sif.sync)
   );

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   logic [3:0] eff_now;
   logic [3:0] ev;
   logic acc;
   logic rd_acc;
   logic rd_state;

   always_comb begin
      // Loopback feeds the control bits back where the pins would be. [RQ6]
      if (s_q.ctl[umc_pkg::CTL_LOOP]) begin
         eff_now[umc_pkg::IN_CTS] = s_q.ctl[umc_pkg::CTL_RTS]; // [RQ15]
         eff_now[umc_pkg::IN_DSR] = s_q.ctl[umc_pkg::CTL_DTR]; // [RQ16]
         eff_now[umc_pkg::IN_RI] = s_q.ctl[umc_pkg::CTL_AUX1]; // [RQ17]
         eff_now[umc_pkg::IN_DCD] = s_q.ctl[umc_pkg::CTL_AUX2]; // [RQ18]
      end else begin
         eff_now = ~sif.pins_n; // [RQ22]
      end
      // Flags compare observed values only, so entering or leaving
      // loopback raises a flag only if the value really differs. [RQ23] [RQ7]
      ev[umc_pkg::IN_CTS] = eff_now[umc_pkg::IN_CTS] ^
                            s_q.eff[umc_pkg::IN_CTS]; // [RQ11]
      ev[umc_pkg::IN_DSR] = eff_now[umc_pkg::IN_DSR] ^
                            s_q.eff[umc_pkg::IN_DSR]; // [RQ12]
      // Ring pin going low to high means the active level falls. [RQ13]
      ev[umc_pkg::IN_RI] = s_q.eff[umc_pkg::IN_RI] &
                           ~eff_now[umc_pkg::IN_RI];
      ev[umc_pkg::IN_DCD] = eff_now[umc_pkg::IN_DCD] ^
                            s_q.eff[umc_pkg::IN_DCD]; // [RQ14]
   end

   assign acc = hsel & htrans[1] & hready;
   assign rd_acc = acc & ~hwrite;
   assign rd_state = rd_acc & (haddr[7:0] == umc_pkg::STATE_OFS);

   always_comb begin
      s_d = s_q;
      s_d.ready = 1'b1;
      s_d.eff = eff_now;

      // Write data phase; the slave is always ready so it ends here.
      if (s_q.wr_pend) begin
         case (s_q.wr_addr)
            umc_pkg::CTL_OFS: begin
               s_d.ctl = hwdata[umc_pkg::CTL_W-1:0]; // [RQ9]
            end
            umc_pkg::SCRATCH_OFS: begin
               s_d.scratch = hwdata[7:0]; // [RQ19]
            end
            default: begin
               s_d.ctl = s_q.ctl;
            end
         endcase
      end
      s_d.wr_pend = acc & hwrite;
      s_d.wr_addr = haddr[7:0];

      // Control read data is taken from the post-write value so that a read
      // right behind a control write sees the new contents.
      s_d.rdata = 32'h0000_0000;
      if (rd_acc) begin
         case (haddr[7:0])
            umc_pkg::CTL_OFS: begin
               s_d.rdata = {27'h0, s_d.ctl}; // [RQ9]
            end
            umc_pkg::STATE_OFS: begin
               s_d.rdata = {24'h0, s_q.eff, s_q.chg}; // [RQ15] [RQ16]
            end
            umc_pkg::SCRATCH_OFS: begin
               s_d.rdata = {24'h0, s_q.scratch}; // [RQ19]
            end
            default: begin
               s_d.rdata = 32'h0000_0000;
            end
         endcase
      end

      // A change in the reading cycle survives the clear. [RQ10] [RQ22]
      s_d.chg = (rd_state ? 4'h0 : s_q.chg) | ev;
      s_d.irq = msi_enable & (|s_d.chg); // [RQ20] [RQ21]

      // Pins are the complement of the control bits, and idle high in
      // loopback. [RQ1] [RQ2] [RQ3] [RQ4] [RQ6]
      for (int i = 0; i < umc_pkg::N_OUT; i++) begin
         s_d.hs_n[i] = s_d.ctl[umc_pkg::CTL_LOOP] | ~s_d.ctl[i];
      end
      // Transmit pin marks in loopback and the receiver hears the
      // transmitter, so both data paths keep raising their own
      // interrupts outside. [RQ5] [RQ8]
      s_d.tx = s_d.ctl[umc_pkg::CTL_LOOP] | tx_shift_out;
      s_d.rxin = s_d.ctl[umc_pkg::CTL_LOOP] ? tx_shift_out : sif.rx;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= STATE_RST;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign hrdata = s_q.rdata;
   assign hreadyout = s_q.ready;
   assign hresp = 1'b0;
   assign terminal_ready_n = s_q.hs_n[umc_pkg::CTL_DTR];
   assign request_to_send_n = s_q.hs_n[umc_pkg::CTL_RTS];
   assign aux_out1_n = s_q.hs_n[umc_pkg::CTL_AUX1];
   assign aux_out2_n = s_q.hs_n[umc_pkg::CTL_AUX2];
   assign serial_tx_pin = s_q.tx;
   assign rx_shift_in = s_q.rxin;
   assign modem_status_irq = s_q.irq;

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   a_dtr_polarity: assert property (@(posedge hclk) disable iff (!hresetn)
      !s_q.ctl[umc_pkg::CTL_LOOP] |->
         terminal_ready_n == !s_q.ctl[umc_pkg::CTL_DTR]) // [RQ1]
      else $error("terminal ready pin polarity wrong");

   a_rts_polarity: assert property (@(posedge hclk) disable iff (!hresetn)
      !s_q.ctl[umc_pkg::CTL_LOOP] |->
         request_to_send_n == !s_q.ctl[umc_pkg::CTL_RTS]) // [RQ2]
      else $error("request to send pin polarity wrong");

   a_aux1_polarity: assert property (@(posedge hclk) disable iff (!hresetn)
      !s_q.ctl[umc_pkg::CTL_LOOP] |->
         aux_out1_n == !s_q.ctl[umc_pkg::CTL_AUX1]) // [RQ3]
      else $error("aux one pin polarity wrong");

   a_aux2_polarity: assert property (@(posedge hclk) disable iff (!hresetn)
      !s_q.ctl[umc_pkg::CTL_LOOP] |->
         aux_out2_n == !s_q.ctl[umc_pkg::CTL_AUX2]) // [RQ4]
      else $error("aux two pin polarity wrong");

   a_loop_pins_idle: assert property (@(posedge hclk) disable iff (!hresetn)
      s_q.ctl[umc_pkg::CTL_LOOP] |-> serial_tx_pin &&
         terminal_ready_n && request_to_send_n &&
         aux_out1_n && aux_out2_n) // [RQ5] [RQ6]
      else $error("pins not idle in loopback");

   a_loop_data_path: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(ce) && s_q.ctl[umc_pkg::CTL_LOOP] |->
         rx_shift_in == $past(tx_shift_out)) // [RQ5]
      else $error("loopback does not carry transmit data");

   a_ctl_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && rd_acc && haddr[7:0] == umc_pkg::CTL_OFS |=>
         hrdata[31:5] == 27'h0) // [RQ9]
      else $error("control upper bits not zero");

   a_cts_change: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && ev[umc_pkg::IN_CTS] |=> s_q.chg[umc_pkg::IN_CTS]) // [RQ11]
      else $error("clear to send change not flagged");

   a_ring_rise_only: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && !s_q.chg[umc_pkg::IN_RI] && !s_q.eff[umc_pkg::IN_RI] |=>
         !s_q.chg[umc_pkg::IN_RI]) // [RQ13]
      else $error("ring flag set on wrong edge");

   a_read_clears: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && rd_state && ev == 4'h0 |=> s_q.chg == 4'h0) // [RQ10]
      else $error("state read did not clear flags");

   a_irq_gated: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && !msi_enable |=> !modem_status_irq) // [RQ20]
      else $error("status interrupt not gated by enable");

   a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && msi_enable && (|ev) |=> modem_status_irq) // [RQ21]
      else $error("status interrupt not raised on change");

endmodule // umc_modem_ctrl

/* File: umc_modem_model.sv */
// Purpose: Modem side model for the handshake and serial input pins.
// Assumes: The bench requests pin levels; slow mode applies them late.
// Notes: The serial input toggles every cycle so a stale level never hides.

// ----------------------------------------------------------------------
// Modem model
// ----------------------------------------------------------------------
module umc_modem_model (
   input wire logic hclk,
   input wire logic slow,
   input wire logic [3:0] want_n,
   output logic [3:0] pins_n,
   output logic serial_rx_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] dly_q;
   initial begin
      pins_n = 4'hF;
      dly_q = 4'hF;
      serial_rx_pin = 1'b1;
   end
   always @(posedge hclk) begin
      dly_q <= want_n;
      pins_n <= slow ? dly_q : want_n;
      serial_rx_pin <= ~serial_rx_pin;
   end
endmodule // umc_modem_model

/* File: umc_pkg.sv */
// Purpose: Shared constants for the handshake control and status block.
// Assumes: One aligned 32-bit word per register on an AHB-Lite bus.
// Notes: Register data sits in the low byte; upper bits read as zero.

// ----------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------
package umc_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam logic [ADDR_W-1:0] CTL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] STATE_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] SCRATCH_OFS = 8'h08;

   localparam int unsigned CTL_W = 5;
   localparam int unsigned CTL_DTR = 0;
   localparam int unsigned CTL_RTS = 1;
   localparam int unsigned CTL_AUX1 = 2;
   localparam int unsigned CTL_AUX2 = 3;
   localparam int unsigned CTL_LOOP = 4;

   localparam int unsigned IN_CTS = 0;
   localparam int unsigned IN_DSR = 1;
   localparam int unsigned IN_RI = 2;
   localparam int unsigned IN_DCD = 3;
   localparam int unsigned N_IN = 4;
   localparam int unsigned N_OUT = 4;

   localparam logic [CTL_W-1:0] CTL_RST = 5'h00;
   localparam logic [7:0] SCRATCH_RST = 8'h00;
   localparam logic [3:0] PIN_IDLE_N = 4'hF;
   localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
endpackage : umc_pkg

/* File: umc_sync.sv */
// Purpose: Two-flop synchroniser for the handshake inputs and serial input.
// Assumes: Pins are asynchronous to hclk.
// Notes: Resets to the idle (high) pin level so no change is seen at start.

// ----------------------------------------------------------------------
// Synchroniser
// ----------------------------------------------------------------------
module umc_sync (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic [3:0] pins_n,
   input wire logic serial_rx_pin,
   umc_sync_if.sync sif
);
   typedef struct packed {
      logic [4:0] meta;
      logic [4:0] stable;
   } umc_sync_s;

   umc_sync_s s_q;
   umc_sync_s s_d;

   // The first stage feeds the second stage and nothing else.
   always_comb begin
      s_d = s_q;
      s_d.meta = {serial_rx_pin, pins_n};
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= {5'h1F, 5'h1F};
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign sif.pins_n = s_q.stable[3:0];
   assign sif.rx = s_q.stable[4];
endmodule // umc_sync

/* File: umc_sync_if.sv */
// Purpose: Carries synchronised pin levels from the synchroniser to the core.
// Assumes: Both ends run on hclk.
// Notes: Levels only, no strobes.

// ----------------------------------------------------------------------
// Interface
// ----------------------------------------------------------------------
interface umc_sync_if;
   logic [3:0] pins_n;
   logic rx;
   modport sync (output pins_n, output rx);
   modport core (input pins_n, input rx);
endinterface : umc_sync_if
